// *** src/drph_top.sv ***
// Debug port reset and power handshake with its AHB-Lite register slave
//
// Notes on behaviour
// - Reset acknowledge status at bit 27
// - Writing one raises debug reset request
// - Debug reset leaves port registers untouched
// - Controller acknowledge shows as status one
// - Request registers live in always-on domain
// - Access port reset on debug power-up
// - Absent reset control: acknowledge reads zero
// - Reset pin low holds target, debug reachable
// - Pin low: reset all, release debug
`timescale 1ns/1ps
`include "drph_cfg.svh"

module drph_top
    import drph_pkg::*;
#(
    parameter bit RESET_CTRL_PRESENT = 1'b1,
    parameter bit REQ_RW_WHEN_ABSENT = 1'b0
)
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             debug_reset_request,
    output logic             debug_powerup_request,
    output logic             system_powerup_request,
    input  wire logic        debug_reset_acknowledge,
    input  wire logic        debug_powerup_acknowledge,
    input  wire logic        system_powerup_acknowledge,
    input  wire logic        system_reset_pin_n,
    output logic             nondebug_reset_n,
    output logic             debug_domain_reset_n
);

    // ============================================================
    // Acknowledge synchronisers
    localparam int SYNC_W = 3;
    logic [SYNC_W-1:0] ack_in;
    logic [SYNC_W-1:0] sync1_reg;
    logic [SYNC_W-1:0] sync2_reg;
    logic [SYNC_W-1:0] sync1_next;
    logic [SYNC_W-1:0] sync2_next;
    drph_ack_type      ack_sts;

    assign ack_in = {system_powerup_acknowledge, debug_powerup_acknowledge,
                     debug_reset_acknowledge};

    genvar gi;
    generate
        for (gi = 0; gi < SYNC_W; gi++)
        begin : g_sync
            always_comb
            begin
                sync1_next[gi] = ack_in[gi];
                sync2_next[gi] = sync1_reg[gi];
            end
        end
    endgenerate

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end
        else
        begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
        end
    end

    always_comb
    begin
        ack_sts         = drph_ack_type'(sync2_reg);
        // Without reset control the acknowledge field reads zero
        ack_sts.dbg_rst = sync2_reg[0] & RESET_CTRL_PRESENT;
    end

    // ============================================================
    // AHB-Lite slave; zero wait states, always OKAY
    logic              wr_pend_reg;
    logic              wr_pend_next;
    logic [7:0]        wr_addr_reg;
    logic [7:0]        wr_addr_next;
    logic [31:0]       rdata_reg;
    logic [31:0]       rdata_next;
    drph_req_type      req_reg;
    drph_req_type      req_next;
    logic              addr_ok;

    assign addr_ok = hsel && hready && htrans[1];

    always_comb
    begin
        wr_pend_next = addr_ok && hwrite;
        wr_addr_next = haddr[7:0];
        rdata_next   = 32'h0000_0000;
        if (addr_ok && !hwrite)
        begin
            case (haddr[7:0])
                `DRPH_CTRL_STAT_OFFSET:
                begin
                    rdata_next[`DRPH_DBG_RST_REQ_BIT] = req_reg.dbg_rst;
                    rdata_next[`DRPH_DBG_RST_ACK_BIT] = ack_sts.dbg_rst;
                    rdata_next[`DRPH_DBG_PWR_REQ_BIT] = req_reg.dbg_pwr;
                    rdata_next[`DRPH_DBG_PWR_ACK_BIT] = ack_sts.dbg_pwr;
                    rdata_next[`DRPH_SYS_PWR_REQ_BIT] = req_reg.sys_pwr;
                    rdata_next[`DRPH_SYS_PWR_ACK_BIT] = ack_sts.sys_pwr;
                end
                `DRPH_PIN_STAT_OFFSET:
                begin
                    rdata_next[`DRPH_PIN_LEVEL_BIT]  = system_reset_pin_n;
                    rdata_next[`DRPH_NONDBG_RST_BIT] = nondebug_reset_n;
                    rdata_next[`DRPH_DBG_DOM_RST_BIT] = debug_domain_reset_n;
                end
                default:
                begin
                    rdata_next = 32'h0000_0000;
                end
            endcase
        end
    end

    // Request fields, reset only by the powerup reset hresetn
    always_comb
    begin
        req_next = req_reg;
        if (wr_pend_reg && wr_addr_reg == `DRPH_CTRL_STAT_OFFSET)
        begin
            req_next.dbg_rst = hwdata[`DRPH_DBG_RST_REQ_BIT]
                & (RESET_CTRL_PRESENT | REQ_RW_WHEN_ABSENT);
            req_next.dbg_pwr = hwdata[`DRPH_DBG_PWR_REQ_BIT];
            req_next.sys_pwr = hwdata[`DRPH_SYS_PWR_REQ_BIT];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            rdata_reg   <= 32'h0000_0000;
            req_reg     <= drph_req_type'(`DRPH_REQ_RESET);
        end
        else
        begin
            wr_pend_reg <= wr_pend_next;
            wr_addr_reg <= wr_addr_next;
            rdata_reg   <= rdata_next;
            req_reg     <= req_next;
        end
    end

    always_comb
    begin
        hrdata                 = rdata_reg;
        hreadyout              = 1'b1;
        hresp                  = 1'b0;
        debug_reset_request    = req_reg.dbg_rst;
        debug_powerup_request  = req_reg.dbg_pwr;
        system_powerup_request = req_reg.sys_pwr;
    end

    // ============================================================
    // System reset pin and debug domain reset sequencer
    localparam logic [3:0] PULSE_LAST = 4'(`DRPH_DBG_RST_PULSE_CYC - 1);
    drph_rst_state_type rs_reg;
    drph_rst_state_type rs_next;
    logic [3:0]         cnt_reg;
    logic [3:0]         cnt_next;
    logic               pin_prev_reg;
    logic               pwr_prev_reg;
    logic               nondbg_reg;
    logic               dbg_dom_reg;
    logic               trigger;

    // Pin fall resets everything; debug power-up resets access ports
    assign trigger = (pin_prev_reg && !system_reset_pin_n)
                   || (ack_sts.dbg_pwr && !pwr_prev_reg);

    always_comb
    begin
        rs_next  = rs_reg;
        cnt_next = cnt_reg;
        case (rs_reg)
            DRPH_RS_IDLE:
            begin
                if (trigger)
                begin
                    rs_next  = DRPH_RS_PULSE;
                    cnt_next = PULSE_LAST;
                end
            end
            DRPH_RS_PULSE:
            begin
                if (trigger)
                begin
                    cnt_next = PULSE_LAST;
                end
                else if (cnt_reg == 4'h0)
                begin
                    rs_next = DRPH_RS_IDLE;
                end
                else
                begin
                    cnt_next = cnt_reg - 4'h1;
                end
            end
            default:
            begin
                rs_next  = DRPH_RS_IDLE;
                cnt_next = 4'h0;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rs_reg       <= DRPH_RS_IDLE;
            cnt_reg      <= 4'h0;
            pin_prev_reg <= 1'b1;
            pwr_prev_reg <= 1'b0;
            nondbg_reg   <= 1'b0;
            dbg_dom_reg  <= 1'b0;
        end
        else
        begin
            rs_reg       <= rs_next;
            cnt_reg      <= cnt_next;
            pin_prev_reg <= system_reset_pin_n;
            pwr_prev_reg <= ack_sts.dbg_pwr;
            nondbg_reg   <= system_reset_pin_n;
            dbg_dom_reg  <= (rs_next != DRPH_RS_PULSE);
        end
    end

    assign nondebug_reset_n     = nondbg_reg;
    assign debug_domain_reset_n = dbg_dom_reg;

    // ============================================================
    // Assertions
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence wr_ctrl_s;
        addr_ok && hwrite && haddr[7:0] == `DRPH_CTRL_STAT_OFFSET;
    endsequence

    sequence rd_ctrl_s;
        addr_ok && !hwrite && haddr[7:0] == `DRPH_CTRL_STAT_OFFSET;
    endsequence

    ack_sync_lat_a: assert property (
        ##2 sync2_reg == $past(ack_in, 2))
        else $error("acknowledge synchroniser latency wrong");

    rst_ack_sts_a: assert property (
        RESET_CTRL_PRESENT && debug_reset_acknowledge ##1
        debug_reset_acknowledge |=> ack_sts.dbg_rst)
        else $error("reset acknowledge not shown in status");

    ack_absent_a: assert property (
        !RESET_CTRL_PRESENT |-> !ack_sts.dbg_rst && (REQ_RW_WHEN_ABSENT
        || !debug_reset_request))
        else $error("absent reset control not read as zero");

    rst_req_wr_a: assert property (
        wr_ctrl_s ##1 1'b1 |=> debug_reset_request ==
        ($past(hwdata[`DRPH_DBG_RST_REQ_BIT]) & (RESET_CTRL_PRESENT
        | REQ_RW_WHEN_ABSENT)))
        else $error("reset request does not follow write");

    ctrl_read_a: assert property (
        rd_ctrl_s |=> hrdata[`DRPH_DBG_RST_ACK_BIT] == $past(ack_sts.dbg_rst)
        && hrdata[`DRPH_DBG_RST_REQ_BIT] == $past(debug_reset_request))
        else $error("control read data wrong");

    pin_hold_a: assert property (
        !system_reset_pin_n |=> !nondebug_reset_n)
        else $error("non-debug domain not held in reset");

    pin_pulse_a: assert property (
        $fell(system_reset_pin_n) ##1 system_reset_pin_n == 1'b0
        [*8] |-> ##0 !debug_domain_reset_n ##1 debug_domain_reset_n)
        else $error("debug domain not reset then released");

    pwr_up_rst_a: assert property (
        $rose(ack_sts.dbg_pwr) |=> !debug_domain_reset_n [*8]
        ##1 debug_domain_reset_n || trigger)
        else $error("access port reset missing on power-up");

    bus_okay_a: assert property (
        hreadyout && !hresp)
        else $error("slave not ready or not okay");

endmodule : drph_top

// *** src/drph_cfg.svh ***
// Offsets, field positions, reset values and timing counts of the handshake
`ifndef DRPH_CFG_SVH
`define DRPH_CFG_SVH

// ============================================================
// Register byte offsets
`define DRPH_CTRL_STAT_OFFSET     8'h00
`define DRPH_PIN_STAT_OFFSET      8'h04

// ============================================================
// Control/status field positions
`define DRPH_DBG_RST_REQ_BIT      26
`define DRPH_DBG_RST_ACK_BIT      27
`define DRPH_DBG_PWR_REQ_BIT      28
`define DRPH_DBG_PWR_ACK_BIT      29
`define DRPH_SYS_PWR_REQ_BIT      30
`define DRPH_SYS_PWR_ACK_BIT      31
`define DRPH_PIN_LEVEL_BIT        0
`define DRPH_NONDBG_RST_BIT       1
`define DRPH_DBG_DOM_RST_BIT      2

// ============================================================
// Reset values and timing
`define DRPH_REQ_RESET            3'h0
`define DRPH_CLK_PERIOD_PS        8000
`define DRPH_DBG_RST_PULSE_NS     64
`define DRPH_DBG_RST_PULSE_CYC \
    ((`DRPH_DBG_RST_PULSE_NS * 1000 + `DRPH_CLK_PERIOD_PS - 1) \
     / `DRPH_CLK_PERIOD_PS)

`endif

// *** src/drph_pkg.sv ***
// Types shared by the debug reset and power handshake block
package drph_pkg;

    // ============================================================
    // Request and acknowledge bundles
    typedef struct packed {
        logic sys_pwr;
        logic dbg_pwr;
        logic dbg_rst;
    } drph_req_type;

    typedef drph_req_type drph_ack_type;

    // ============================================================
    // Debug domain reset sequencer
    typedef enum logic [0:0] {
        DRPH_RS_IDLE  = 1'b0,
        DRPH_RS_PULSE = 1'b1
    } drph_rst_state_type;

endpackage : drph_pkg

// *** verification/drph_partner.sv ***
// Behavioural reset and power controller beside the handshake block
`timescale 1ns/1ps

module drph_partner
    import drph_pkg::*;
#(
    parameter logic [3:0] RST_LAG       = 4'h6,
    parameter bit         DEVICE_ENABLE = 1'b1
)
(
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire drph_req_type req,
    output drph_ack_type      ack
);
    // ========
    // Acknowledges follow requests; the reset one lags
    logic [3:0] cnt_reg [3];

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ack <= '0;
            cnt_reg <= '{default: 4'h0};
        end
        else
        begin
            for (int i = 0; i < 3; i++)
            begin
                cnt_reg[i] <= (req[i] != ack[i]) ? cnt_reg[i] + 4'h1 : 4'h0;
                // Reset request ignored while the device is disabled
                if (req[i] != ack[i] && (i != 0 ||
                    (DEVICE_ENABLE && cnt_reg[i] >= RST_LAG)))
                    ack[i] <= req[i];
            end
        end
    end
endmodule : drph_partner

// *** verification/drph_top_test.sv ***
// Self-checking bench for the debug reset and power handshake
`timescale 1ns/1ps
`include "drph_cfg.svh"

module drph_top_test
    import drph_pkg::*;
;
    localparam logic [31:0] M_RR = 32'h1 << `DRPH_DBG_RST_REQ_BIT;
    localparam logic [31:0] M_RA = 32'h1 << `DRPH_DBG_RST_ACK_BIT;
    localparam logic [31:0] M_DR = 32'h1 << `DRPH_DBG_PWR_REQ_BIT;
    localparam logic [31:0] M_DA = 32'h1 << `DRPH_DBG_PWR_ACK_BIT;
    localparam logic [31:0] M_SR = 32'h1 << `DRPH_SYS_PWR_REQ_BIT;
    localparam logic [31:0] M_SA = 32'h1 << `DRPH_SYS_PWR_ACK_BIT;
    localparam logic [31:0] A_CS = 32'(`DRPH_CTRL_STAT_OFFSET);
    localparam logic [31:0] A_PS = 32'(`DRPH_PIN_STAT_OFFSET);
    localparam int          PLEN = `DRPH_DBG_RST_PULSE_CYC;
    localparam int          LIMIT = 5000;

    logic         hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0;
    logic         hwrite = 1'b0, pin_n = 1'b1;
    logic [1:0]   htrans = 2'h0;
    logic [31:0]  haddr = 32'h0, hwdata = 32'h0, rd;
    wire          hready, hresp, nondbg_n, dbgdom_n;
    wire  [31:0]  hrdata;
    wire drph_req_type req;
    wire drph_ack_type ack;
    logic         nr_ack = 1'b0;
    wire          nr_rr;
    wire  [31:0]  hrdata_nr;
    logic [31:0]  rd_nr;
    int           fail_count = 0, comparisons = 0, cycles = 0;

    always #4 hclk = ~hclk;

    drph_top i_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
        .debug_reset_request(req.dbg_rst),
        .debug_powerup_request(req.dbg_pwr),
        .system_powerup_request(req.sys_pwr),
        .debug_reset_acknowledge(ack.dbg_rst),
        .debug_powerup_acknowledge(ack.dbg_pwr),
        .system_powerup_acknowledge(ack.sys_pwr),
        .system_reset_pin_n(pin_n), .nondebug_reset_n(nondbg_n),
        .debug_domain_reset_n(dbgdom_n)
    );

    drph_partner i_ctrl (.hclk(hclk), .hresetn(hresetn), .req(req), .ack(ack));

    // Second block without reset control, for the read-as-zero fields
    drph_top #(.RESET_CTRL_PRESENT(1'b0)) i_dut_nr (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata_nr), .hreadyout(), .hresp(),
        .debug_reset_request(nr_rr), .debug_powerup_request(),
        .system_powerup_request(),
        .debug_reset_acknowledge(nr_ack),
        .debug_powerup_acknowledge(ack.dbg_pwr),
        .system_powerup_acknowledge(ack.sys_pwr),
        .system_reset_pin_n(pin_n), .nondebug_reset_n(),
        .debug_domain_reset_n()
    );

    // ========
    // Helpers
    task automatic chk(input string w, input logic [31:0] s,
                       input logic [31:0] e);
        comparisons++;
        if (s !== e)
        begin
            $display("ERROR %s expected %h seen %h", w, e, s);
            fail_count++;
        end
    endtask : chk

    task automatic bus(input logic wr, input logic [31:0] a,
                       input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        rd_nr = hrdata_nr;
    endtask : bus

    task automatic poll(input int b, input logic v);
        bus(1'b0, A_CS, 32'h0);
        for (int n = 0; n < 64 && rd[b] !== v; n++)
            bus(1'b0, A_CS, 32'h0);
    endtask : poll

    task automatic pulse(output int len);
        len = 0;
        for (int n = 0; n < 64 && dbgdom_n !== 1'b0; n++)
            @(posedge hclk);
        while (dbgdom_n === 1'b0 && len < 64)
        begin
            @(posedge hclk);
            len++;
        end
    endtask : pulse

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : wrap_up

    always @(posedge hclk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            fail_count++;
            wrap_up;
        end
    end

    // ========
    // Scenarios
    task automatic t_map;
        chk("hresp", {31'h0, hresp}, 32'h0);
        chk("hready", {31'h0, hready}, 32'h1);
        bus(1'b1, 32'h8, 32'hffffffff);
        bus(1'b0, 32'h8, 32'h0);
        chk("unmapped", rd, 32'h0);
        bus(1'b1, A_CS, M_RA | M_DA | M_SA);
        bus(1'b0, A_CS, 32'h0);
        chk("ctrl ro", rd, 32'h0);
        bus(1'b0, A_PS, 32'h0);
        chk("pin idle", rd, 32'h7);
    endtask : t_map

    task automatic t_rst;
        bus(1'b1, A_CS, M_DR);
        poll(29, 1'b1);
        bus(1'b1, A_CS, M_DR | M_RR);
        #1 chk("rst req", {31'h0, req.dbg_rst}, 32'h1);
        chk("absent req", {31'h0, nr_rr}, 32'h0);
        @(posedge hclk);
        bus(1'b0, A_CS, 32'h0);
        chk("ack sync", rd, M_DR | M_DA | M_RR);
        poll(27, 1'b1);
        chk("rst ack", rd, M_DR | M_DA | M_RR | M_RA);
        // Acknowledge raised on purpose: the field must still read zero
        nr_ack <= 1'b1;
        repeat (2) @(posedge hclk);
        bus(1'b0, A_CS, 32'h0);
        chk("absent ack", rd_nr, M_DR | M_DA);
        nr_ack <= 1'b0;
        bus(1'b1, A_CS, M_DR);
        #1 chk("rst drop", {31'h0, req.dbg_rst}, 32'h0);
        @(posedge hclk);
        poll(27, 1'b0);
        chk("ack drop", rd, M_DR | M_DA);
    endtask : t_rst

    task automatic t_pwr;
        int len;
        bus(1'b1, A_CS, M_DR | M_SR);
        poll(31, 1'b1);
        chk("pwr ack", rd, M_DR | M_DA | M_SR | M_SA);
        bus(1'b1, A_CS, 32'h0);
        poll(29, 1'b0);
        poll(31, 1'b0);
        chk("pwr off", rd, 32'h0);
        bus(1'b1, A_CS, M_DR);
        pulse(len);
        chk("pwr pulse", len, PLEN);
    endtask : t_pwr

    task automatic t_pin;
        int len;
        bus(1'b1, A_CS, 32'h0);
        poll(29, 1'b0);
        pin_n <= 1'b0;
        pulse(len);
        chk("pin pulse", len, PLEN);
        chk("nondbg", {31'h0, nondbg_n}, 32'h0);
        bus(1'b0, A_PS, 32'h0);
        chk("pin low", rd, 32'h4);
        bus(1'b1, A_CS, M_DR);
        pulse(len);
        chk("up pulse", len, PLEN);
        poll(29, 1'b1);
        chk("dbg up", rd, M_DR | M_DA);
        pin_n <= 1'b1;
        repeat (2) @(posedge hclk);
        bus(1'b0, A_PS, 32'h0);
        chk("pin high", rd, 32'h7);
        hresetn <= 1'b0;
        @(posedge hclk);
        #1 chk("por req", {29'h0, req}, 32'h0);
        @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b0, A_CS, 32'h0);
        chk("por ctrl", rd, 32'h0);
    endtask : t_pin

    initial
    begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_map;
        t_rst;
        t_pwr;
        t_pin;
        wrap_up;
    end
endmodule : drph_top_test
